// >>> dv/pcout_board.sv
// board model: counts rising edges on the three clock pins
// assumes the pins change only on the system clock
`timescale 1ns/1ns
module pcout_board (
  input wire clk,
  input wire [2:0] pins,
  output logic [2:0][15:0] rises
);
  logic [2:0] last = 3'h7;
  initial rises = 48'h0;
  // edges faster than clk would be missed, fine for registered pins
  always @(posedge clk)
  begin
    last <= pins;
    for (int i = 0; i < 3; i++)
      if (pins[i] && !last[i]) rises[i] <= rises[i] + 16'h1;
  end
endmodule // pcout_board

// >>> dv/pcout_props.sv
// assertions on the port clocking outputs
// assumes address and data of a write are offered together
`timescale 1ns/1ns
module pcout_props (
  input wire clk,
  input wire rst_b,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire timer_clock,
  input wire osc_clock,
  input wire ref_generator_clock,
  input wire first_clock_pin,
  input wire second_clock_pin,
  input wire third_clock_pin,
  input wire [7:0] port_pin_enable
);
  reg [7:0] lvl, cfg, misc, refc;
  wire quiet = s_axi_awready && !s_axi_awvalid;
  // shadow registers, taken with the address since data rides along
  always @(posedge clk)
    if (!rst_b)
      {lvl, cfg, misc, refc} <= 32'hff008000;
    else if (s_axi_awvalid && s_axi_awready)
      case (s_axi_awaddr[9:0])
        10'h010: lvl <= s_axi_wdata[7:0];
        10'h030: cfg <= s_axi_wdata[7:0];
        10'h0e8: misc <= s_axi_wdata[7:0];
        10'h18c: refc <= s_axi_wdata[7:0];
        default: ;
      endcase
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // pin behaviour
  // ****
  a_tco_cause:
    assert property ((quiet && misc[0]) [*3] ##1 $changed(first_clock_pin)
      |-> $past(timer_clock) || $past(timer_clock, 2)) else $error("pin 0 moved alone");
  a_tco_hold:
    assert property ((quiet && !misc[0]) [*3] |=> $stable(first_clock_pin))
      else $error("pin 0 toggled while off");
  a_osc_pass:
    assert property ((misc[1] && refc[5:4] == 2'h0) [*4]
      |-> second_clock_pin == $past(osc_clock, 2)) else $error("pin 1 not osc");
  a_osc_level:
    assert property ((!misc[1] && $stable(lvl)) [*4] |-> second_clock_pin == lvl[1])
      else $error("pin 1 not level");
  a_ref_follow:
    assert property (misc[2] [*4] |-> third_clock_pin == $past(ref_generator_clock))
      else $error("pin 2 not ref");
  a_ref_level:
    assert property ((!misc[2] && $stable(lvl)) [*4] |-> third_clock_pin == lvl[2])
      else $error("pin 2 not level");
  a_enable_copy:
    assert property ($stable(cfg) [*3] |-> port_pin_enable == cfg) else $error("enable");
  a_pins_reset:
    assert property (disable iff (1'b0) !rst_b |=> {first_clock_pin, second_clock_pin,
      third_clock_pin, port_pin_enable} == 11'h700) else $error("reset state");
endmodule // pcout_props

// >>> dv/test_port_clocking_outputs.sv
// bench for the port clocking outputs
// assumes the board model watches the three pins
`timescale 1ns/1ns
module test_port_clocking_outputs;
  logic clk = 0, rst_b = 0, timer_clock = 0, osc_clock = 0, ref_generator_clock = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
  logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_rvalid, first_clock_pin, second_clock_pin, third_clock_pin;
  logic [7:0] port_pin_enable;
  logic [2:0][15:0] rises;
  logic [15:0] c1, c2;
  int num_errors = 0, cmp_count = 0, cyc = 0, n;
  pcout_top DUT (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_clock, .osc_clock,
    .ref_generator_clock, .first_clock_pin, .second_clock_pin, .third_clock_pin,
    .port_pin_enable);
  pcout_board pb (.clk, .pins({third_clock_pin, second_clock_pin, first_clock_pin}), .rises);
  initial forever #20 clk = ~clk;
  // slow clocks of 4 and 6 cycles, so windows of 384 hold whole periods
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    osc_clock <= cyc[1];
    ref_generator_clock <= cyc % 6 < 3;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end
    while (s_axi_bvalid !== 1'h1 && n < 50);
    chk(s_axi_bresp, r);
    if (n == 50)
    begin
      num_errors++;
      complete_run;
    end
  endtask
  task automatic rd(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end
    while (s_axi_rvalid !== 1'h1 && n < 50);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    if (n == 50)
    begin
      num_errors++;
      complete_run;
    end
  endtask
  // one count pulse every 4 cycles
  task automatic pulse(input int k);
    repeat (k)
    begin
      timer_clock <= 1'h1;
      @(posedge clk);
      timer_clock <= 1'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  task complete_run;
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    chk({third_clock_pin, second_clock_pin, first_clock_pin}, 32'h7);
    rd(32'h10, 32'hff);
    rd(32'h30, 32'h00);
    rd(32'he8, 32'h80);
    rd(32'h18c, 32'h00);
    rd(32'h200, 32'h00, 2'h2);
    wr(32'h200, 32'h55, 2'h2);
    wr(32'he8, 32'hff);
    rd(32'he8, 32'hf7);
    wr(32'h30, 32'h5a);
    rd(32'h30, 32'h5a);
    chk(port_pin_enable, 32'h5a);
    wr(32'he8, 32'h86);
    for (int i = 0; i < 4; i++)
    begin
      wr(32'h18c, i << 4);
      repeat (40) @(posedge clk);
      c1 = rises[1];
      c2 = rises[2];
      repeat (384) @(posedge clk);
      chk(rises[1] - c1, 32'h60 >> i);
      chk(rises[2] - c2, 32'h40);
    end
    wr(32'h10, 32'hf9);
    wr(32'he8, 32'h81);
    repeat (4) @(posedge clk);
    chk({third_clock_pin, second_clock_pin}, 32'h0);
    wr(32'h1c0, 32'h8000);
    pulse(4095);
    chk(first_clock_pin, 32'h1);
    pulse(1);
    chk(first_clock_pin, 32'h0);
    rd(32'h10, 32'hf8);
    pulse(4096);
    chk(first_clock_pin, 32'h1);
    wr(32'he8, 32'h80);
    pulse(4096);
    chk(first_clock_pin, 32'h1);
    wr(32'h10, 32'hf8);
    repeat (4) @(posedge clk);
    chk(first_clock_pin, 32'h0);
    complete_run;
  end
endmodule // test_port_clocking_outputs
bind pcout_top pcout_props u_props (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .timer_clock, .osc_clock, .ref_generator_clock,
  .first_clock_pin, .second_clock_pin, .third_clock_pin, .port_pin_enable);

// >>> logic/pcout_osc_div.v
// oscillator divider for the second clock pin
// assumes osc_clock already sampled into the clk domain
`timescale 1ns/1ns
`include "pcout_consts.vh"
module pcout_osc_div (
  input wire clk,
  input wire rst_b,
  input wire osc_clock,
  input wire [1:0] osc_divider_select,
  output reg divided_osc_clock
);
  reg osc_last;
  reg [2:0] div_count;
  wire osc_rise;
  assign osc_rise = osc_clock & ~osc_last;
  // count oscillator rising edges, taps give /2 /4 /8
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      osc_last <= 1'b0;
      div_count <= 3'h0;
      divided_osc_clock <= 1'b0;
    end
    else
    begin
      osc_last <= osc_clock;
      if (osc_rise)
        div_count <= div_count + `PCOUT_DIV_ONE;
      case (osc_divider_select)
        2'b00: divided_osc_clock <= osc_clock;
        2'b01: divided_osc_clock <= div_count[0];
        2'b10: divided_osc_clock <= div_count[1];
        default: divided_osc_clock <= div_count[2];
      endcase
    end
  end
endmodule // pcout_osc_div

// >>> logic/pcout_top.v
// port clocking outputs with an axi4-lite register slave
// assumes osc_clock and ref_generator_clock are synchronous to clk, well below its rate
`timescale 1ns/1ns
`include "pcout_consts.vh"
module pcout_top (
  input wire clk,
  input wire rst_b,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire timer_clock,
  input wire osc_clock,
  input wire ref_generator_clock,
  output reg first_clock_pin,
  output reg second_clock_pin,
  output reg third_clock_pin,
  output reg [7:0] port_pin_enable
);
  // ****************************************
  // registers and state
  // ****************************************
  reg [7:0] port_e_output_level;
  reg [7:0] port_e_config;
  reg [7:0] port_misc_control;
  reg [7:0] reference_osc_control;
  reg [15:0] timer_control;
  reg [11:0] first_timer;
  reg timer_tick_last;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_index;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [7:0] next_level;
  reg [31:0] next_rdata;
  reg next_rhit;
  wire timer_clock_out_enable;
  wire osc_clock_out_enable;
  wire ref_clock_out_enable;
  wire timer_tick;
  wire timer_overflow;
  wire divided_osc_clock;
  wire do_write;
  wire w_hit;
  wire [7:0] ar_index;
  assign timer_clock_out_enable = port_misc_control[`PCOUT_BIT_TCO];
  assign osc_clock_out_enable = port_misc_control[`PCOUT_BIT_OSC];
  assign ref_clock_out_enable = port_misc_control[`PCOUT_BIT_REF];
  assign timer_tick = timer_clock & ~timer_tick_last;
  // overflow only when counting from all ones back to zero
  assign timer_overflow = timer_control[`PCOUT_BIT_TEN] & timer_tick
    & (first_timer == `PCOUT_TMR_MAX);
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign ar_index = s_axi_araddr[`PCOUT_IDX_HI:`PCOUT_IDX_LO];
  assign w_hit = (aw_index == `PCOUT_IDX_LEVEL) | (aw_index == `PCOUT_IDX_CONFIG)
    | (aw_index == `PCOUT_IDX_MISC) | (aw_index == `PCOUT_IDX_REFCTL)
    | (aw_index == `PCOUT_IDX_TIMER);
  // ****************************************
  // oscillator divider
  // ****************************************
  pcout_osc_div u_div (
    .clk(clk),
    .rst_b(rst_b),
    .osc_clock(osc_clock),
    .osc_divider_select(reference_osc_control[`PCOUT_DIV_HI:`PCOUT_DIV_LO]),
    .divided_osc_clock(divided_osc_clock)
  );
  // ****************************************
  // port level register with toggling bit 0
  // ****************************************
  // a software write to bit 0 loses to nothing: the toggle applies on top of it
  always @*
  begin
    next_level = port_e_output_level;
    if (do_write && aw_index == `PCOUT_IDX_LEVEL && w_strb[0])
      next_level = w_data[7:0];
    if (timer_clock_out_enable && timer_overflow)
      next_level[0] = ~next_level[0];
  end
  // read mux, unmapped words read zero with an error answer
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_rhit = 1'b1;
    case (ar_index)
      `PCOUT_IDX_LEVEL: next_rdata[7:0] = port_e_output_level;
      `PCOUT_IDX_CONFIG: next_rdata[7:0] = port_e_config;
      `PCOUT_IDX_MISC: next_rdata[7:0] = port_misc_control;
      `PCOUT_IDX_REFCTL: next_rdata[7:0] = reference_osc_control;
      `PCOUT_IDX_TIMER: next_rdata = {4'h0, first_timer, timer_control};
      default: next_rhit = 1'b0;
    endcase
  end
  // ****************************************
  // axi write and read channels
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCOUT_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PCOUT_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      // address and data may come in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_index <= s_axi_awaddr[`PCOUT_IDX_HI:`PCOUT_IDX_LO];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? `PCOUT_RESP_OK : `PCOUT_RESP_ERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rhit ? `PCOUT_RESP_OK : `PCOUT_RESP_ERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // ****************************************
  // register file and first timer
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      port_e_output_level <= `PCOUT_RST_LEVEL;
      port_e_config <= `PCOUT_RST_CONFIG;
      port_misc_control <= `PCOUT_RST_MISC;
      reference_osc_control <= `PCOUT_RST_REFCTL;
      timer_control <= `PCOUT_RST_TIMER;
      first_timer <= `PCOUT_RST_COUNT;
      timer_tick_last <= 1'b0;
    end
    else
    begin
      port_e_output_level <= next_level;
      timer_tick_last <= timer_clock;
      // twelve-bit up counter, wraps naturally
      if (timer_control[`PCOUT_BIT_TEN] && timer_tick)
        first_timer <= first_timer + `PCOUT_TMR_ONE;
      if (do_write && w_strb[0])
      begin
        case (aw_index)
          `PCOUT_IDX_CONFIG: port_e_config <= w_data[7:0];
          `PCOUT_IDX_MISC: port_misc_control <= w_data[7:0] & `PCOUT_MISC_MASK;
          `PCOUT_IDX_REFCTL: reference_osc_control <= w_data[7:0] & `PCOUT_REFCTL_MASK;
          `PCOUT_IDX_TIMER: timer_control[7:0] <= w_data[7:0];
          default: ;
        endcase
      end
      if (do_write && w_strb[1] && aw_index == `PCOUT_IDX_TIMER)
        timer_control[15:8] <= w_data[15:8];
    end
  end
  // ****************************************
  // pin multiplexers
  // ****************************************
  // each pin drops back to its port level when its function is off
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      first_clock_pin <= 1'b1;
      second_clock_pin <= 1'b1;
      third_clock_pin <= 1'b1;
      port_pin_enable <= 8'h00;
    end
    else
    begin
      first_clock_pin <= next_level[0];
      second_clock_pin <= osc_clock_out_enable ? divided_osc_clock
        : port_e_output_level[1];
      third_clock_pin <= ref_clock_out_enable ? ref_generator_clock
        : port_e_output_level[2];
      port_pin_enable <= port_e_config;
    end
  end
endmodule // pcout_top

// >>> pkg/pcout_consts.vh
// constants for the port clocking output block
// assumes a 32-bit axi4-lite slave with byte addresses on aligned words
`ifndef PCOUT_CONSTS_VH
`define PCOUT_CONSTS_VH
// ****************************************
// register map
// ****************************************
`define PCOUT_IDX_LEVEL 8'h04
`define PCOUT_IDX_CONFIG 8'h0c
`define PCOUT_IDX_MISC 8'h3a
`define PCOUT_IDX_REFCTL 8'h63
`define PCOUT_IDX_TIMER 8'h70
`define PCOUT_RST_LEVEL 8'hff
`define PCOUT_RST_CONFIG 8'h00
`define PCOUT_RST_MISC 8'h80
`define PCOUT_RST_REFCTL 8'h00
`define PCOUT_RST_TIMER 16'h0000
`define PCOUT_RST_COUNT 12'h000
`define PCOUT_MISC_MASK 8'hf7
`define PCOUT_REFCTL_MASK 8'hb7
// ****************************************
// fields
// ****************************************
`define PCOUT_BIT_TCO 0
`define PCOUT_BIT_OSC 1
`define PCOUT_BIT_REF 2
`define PCOUT_DIV_HI 5
`define PCOUT_DIV_LO 4
`define PCOUT_BIT_TEN 15
`define PCOUT_IDX_HI 9
`define PCOUT_IDX_LO 2
`define PCOUT_TMR_MAX 12'hfff
`define PCOUT_TMR_ONE 12'h001
`define PCOUT_DIV_ONE 3'h1
`define PCOUT_RESP_OK 2'b00
`define PCOUT_RESP_ERR 2'b10
`endif
